// *** asw_defines.svh ***
// timing figures and reset values for the asynchronous memory write controller
`ifndef ASW_DEFINES_SVH
`define ASW_DEFINES_SVH
`define ASW_CLK_PERIOD_NS 40
`define ASW_T_CYCLE_NS 20
`define ASW_T_CS_END_NS 20
`define ASW_T_ADDR_SETUP_NS 0
`define ASW_T_WE_ADDR_HOLD_NS 2
`define ASW_T_CS_ADDR_HOLD_NS 0
`define ASW_T_CS_WIDTH_NS 20
`define ASW_T_WE_WIDTH_NS 20
`define ASW_T_ADDR_END_NS 20
`define ASW_T_BUS_RELEASE_NS 10
`define ASW_T_DATA_SETUP_NS 15
`define ASW_T_DATA_HOLD_NS 2
`define ASW_T_WE_DISABLE_NS 5
`define ASW_T_RETAIN_ENTRY_NS 0
`define ASW_T_RECOVER_NS 20
// least time rounds up, longest time rounds down, never below one cycle
`define ASW_CYC_UP(t) ((((t) + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS) > 0 ? \
  (((t) + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS) : 1)
`define ASW_CYC_DN(t) (((t) / `ASW_CLK_PERIOD_NS) > 0 ? ((t) / `ASW_CLK_PERIOD_NS) : 1)
`define ASW_ADDR_RST 19'h00000
`define ASW_DATA_RST 8'h00
`endif

// *** asw_pkg.sv ***
// types shared by the asynchronous memory write controller
package asw_pkg;
  typedef struct packed {
    logic [18:0] addr;      // word address
    logic [7:0] data;       // byte to store
    logic csCtl;            // 1: chip select ends the write
  } asw_req_t;
  typedef struct packed {
    logic [18:0] addr;      // address pins
    logic chipSel_b;        // chip select, active low
    logic writeStrobe_b;    // write strobe, active low
    logic outDrive_b;       // output drive, active low
    logic [7:0] dataOut;    // data pin output value
    logic dataOe;           // high while we drive the data pins
  } asw_pins_t;
  typedef enum logic [7:0] {
    ASW_IDLE = 8'h01,
    ASW_SETUP = 8'h02,
    ASW_OPEN = 8'h04,
    ASW_DRIVE = 8'h08,
    ASW_HOLD = 8'h10,
    ASW_DONE = 8'h20,
    ASW_RETAIN = 8'h40,
    ASW_RECOVER = 8'h80
  } asw_state_t;
endpackage

// *** asw_delay_timer.sv ***
// down counter that marks the last cycle of a loaded interval
module asw_delay_timer #(
  parameter int W = 4
) (
  input wire logic clock,          // system clock
  input wire logic rst_b,          // async reset, active low
  input wire logic load,           // start a new interval
  input wire logic [W-1:0] cycles, // interval length, at least one
  output logic done                // last cycle of the interval
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  // refuse a width that cannot hold even a one-cycle interval
  if (W < 1) begin : g_bad_width
    $error("asw_delay_timer: width must be at least 1");
  end

  // load minus one so the state lasts exactly the loaded count
  always_comb begin
    count_nxt = count_r;
    if (load) begin
      count_nxt = cycles - W'(1);
    end else if (count_r != '0) begin
      count_nxt = count_r - W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign done = (count_r == '0);
endmodule // asw_delay_timer

// *** asw_sram_writer.sv ***
// host controller driving write cycles into an asynchronous 512k x 8 memory
`include "asw_defines.svh"
module asw_sram_writer (
  input wire logic clock,                  // 25 MHz system clock
  input wire logic rst_b,                  // async reset, active low
  input wire logic reqValid,               // write request offered
  output logic reqReady,                   // request taken this cycle
  input wire asw_pkg::asw_req_t req,       // address, data, end mode
  output logic writeDone,                  // pulse as a write cycle closes
  input wire logic retainReq,              // level: park for supply drop
  output logic retainReady,                // parked, supply may drop
  output asw_pkg::asw_pins_t sramPins,     // memory pins, registered
  input wire logic [7:0] sramDataIn,       // data pin input value
  output logic [7:0] busSample             // synchronised data pin level
);
  import asw_pkg::*;

  localparam int RELEASE_CYC = `ASW_CYC_DN(`ASW_T_BUS_RELEASE_NS);
  localparam int PULSE_A = `ASW_CYC_UP(`ASW_T_CS_WIDTH_NS);
  localparam int PULSE_B = `ASW_CYC_UP(`ASW_T_DATA_SETUP_NS);
  localparam int PULSE_CYC = PULSE_A > PULSE_B ? PULSE_A : PULSE_B;
  localparam int HOLD_A = `ASW_CYC_UP(`ASW_T_DATA_HOLD_NS);
  localparam int HOLD_B = `ASW_CYC_UP(`ASW_T_WE_ADDR_HOLD_NS);
  localparam int HOLD_CYC = HOLD_A > HOLD_B ? HOLD_A : HOLD_B;
  localparam int DISABLE_CYC = `ASW_CYC_UP(`ASW_T_WE_DISABLE_NS);
  localparam int CYCLE_CYC = `ASW_CYC_UP(`ASW_T_CYCLE_NS);
  localparam int RECOVER_CYC = `ASW_CYC_UP(`ASW_T_RECOVER_NS);
  localparam int CS_END_CYC = `ASW_CYC_UP(`ASW_T_CS_END_NS);
  localparam int WE_CYC = `ASW_CYC_UP(`ASW_T_WE_WIDTH_NS);
  localparam int ADDR_END_CYC = `ASW_CYC_UP(`ASW_T_ADDR_END_NS);
  localparam int TW = 4;
  localparam int AGE_MAX = 15;

  // every phase count must fit the timer, the cycle time the age counter
  if ((PULSE_CYC >> TW) != 0 || (RECOVER_CYC >> TW) != 0 || (HOLD_CYC >> TW) != 0 ||
      (DISABLE_CYC >> TW) != 0 || (RELEASE_CYC >> TW) != 0 ||
      CYCLE_CYC > AGE_MAX) begin : g_bad_timing
    $error("asw_sram_writer: timing counts exceed the timer width");
  end

  asw_state_t state_r, state_nxt;
  asw_req_t req_r, req_nxt;
  asw_pins_t pins_r, pins_nxt;
  logic [3:0] addrAge_r, addrAge_nxt;
  logic done_r, done_nxt;
  logic timerLoad;
  logic [TW-1:0] timerCycles;
  logic timerDone;
  logic [7:0] dataMeta_r, dataSync_r;

  asw_delay_timer #(.W(TW)) i_asw_delay_timer (
    .clock(clock),
    .rst_b(rst_b),
    .load(timerLoad),
    .cycles(timerCycles),
    .done(timerDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: OPEN, DRIVE, HOLD and RECOVER last their timer counts, SETUP one cycle, DONE also waits the cycle-time guard
  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    done_nxt = 1'b0;
    timerLoad = 1'b0;
    timerCycles = TW'(1);
    reqReady = 1'b0;
    addrAge_nxt = (addrAge_r == 4'(AGE_MAX)) ? addrAge_r : addrAge_r + 4'h1;
    unique case (state_r)
      ASW_IDLE: begin
        if (retainReq) begin
          state_nxt = ASW_RETAIN;
        end else if (reqValid) begin
          reqReady = 1'b1;
          req_nxt = req;
          addrAge_nxt = 4'h0;
          state_nxt = ASW_SETUP;
        end
      end
      ASW_SETUP: begin
        // a whole cycle of address before any control falls
        timerLoad = 1'b1;
        timerCycles = TW'(RELEASE_CYC);
        state_nxt = ASW_OPEN;
      end
      ASW_OPEN: begin
        if (timerDone) begin
          timerLoad = 1'b1;
          timerCycles = TW'(PULSE_CYC);
          state_nxt = ASW_DRIVE;
        end
      end
      ASW_DRIVE: begin
        if (timerDone) begin
          timerLoad = 1'b1;
          timerCycles = TW'(HOLD_CYC);
          state_nxt = ASW_HOLD;
        end
      end
      ASW_HOLD: begin
        if (timerDone) begin
          timerLoad = 1'b1;
          timerCycles = TW'(DISABLE_CYC);
          state_nxt = ASW_DONE;
        end
      end
      ASW_DONE: begin
        // the cycle-time guard keeps the next address change late enough
        if (timerDone && addrAge_r >= 4'(CYCLE_CYC)) begin
          done_nxt = 1'b1;
          state_nxt = ASW_IDLE;
        end
      end
      ASW_RETAIN: begin
        if (!retainReq) begin
          timerLoad = 1'b1;
          timerCycles = TW'(RECOVER_CYC);
          state_nxt = ASW_RECOVER;
        end
      end
      ASW_RECOVER: begin
        if (timerDone) begin
          state_nxt = ASW_IDLE;
        end
      end
      default: begin
        state_nxt = ASW_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin values follow the next state so pins and state change together
  always_comb begin
    pins_nxt.addr = req_nxt.addr;
    pins_nxt.dataOut = req_nxt.data;
    // read drive stays off, so the memory never fights our data
    pins_nxt.outDrive_b = 1'b1;
    pins_nxt.chipSel_b = 1'b1;
    pins_nxt.writeStrobe_b = 1'b1;
    pins_nxt.dataOe = 1'b0;
    unique case (state_nxt)
      ASW_OPEN: begin
        // strobe mode lowers both; select mode lowers the strobe first
        pins_nxt.chipSel_b = req_nxt.csCtl;
        pins_nxt.writeStrobe_b = 1'b0;
      end
      ASW_DRIVE: begin
        pins_nxt.chipSel_b = 1'b0;
        pins_nxt.writeStrobe_b = 1'b0;
        pins_nxt.dataOe = 1'b1;
      end
      ASW_HOLD: begin
        // the first control to rise ends the write; data and address hold
        pins_nxt.chipSel_b = req_nxt.csCtl;
        pins_nxt.writeStrobe_b = ~req_nxt.csCtl;
        pins_nxt.dataOe = 1'b1;
      end
      default: begin
        pins_nxt.chipSel_b = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ASW_IDLE;
      req_r <= '{addr: `ASW_ADDR_RST, data: `ASW_DATA_RST, csCtl: 1'b0};
      pins_r <= '{addr: `ASW_ADDR_RST, chipSel_b: 1'b1, writeStrobe_b: 1'b1,
                  outDrive_b: 1'b1, dataOut: `ASW_DATA_RST, dataOe: 1'b0};
      addrAge_r <= 4'(AGE_MAX);
      done_r <= 1'b0;
      dataMeta_r <= `ASW_DATA_RST;
      dataSync_r <= `ASW_DATA_RST;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      pins_r <= pins_nxt;
      addrAge_r <= addrAge_nxt;
      done_r <= done_nxt;
      dataMeta_r <= sramDataIn; // pin level, two stages before use
      dataSync_r <= dataMeta_r;
    end
  end

  assign sramPins = pins_r;
  assign writeDone = done_r;
  assign retainReady = (state_r == ASW_RETAIN);
  assign busSample = dataSync_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the pins we drive
  logic [3:0] csLow_r, weLow_r;
  logic writing, writeEnd, writing_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      csLow_r <= 4'h0;
      weLow_r <= 4'h0;
      writing_r <= 1'b0;
    end else begin
      csLow_r <= pins_r.chipSel_b ? 4'h0 : csLow_r + {3'h0, csLow_r != 4'hf};
      weLow_r <= pins_r.writeStrobe_b ? 4'h0 : weLow_r + {3'h0, weLow_r != 4'hf};
      writing_r <= writing;
    end
  end
  assign writing = !pins_r.chipSel_b && !pins_r.writeStrobe_b;
  // registered copy keeps the end detector out of sampled-value functions
  assign writeEnd = writing_r && !writing;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_cs_before_end: assert property (writeEnd |-> csLow_r >= CS_END_CYC)
    else $error("chip select low too short before write end");
  chk_addr_setup_edge: assert property ($fell(pins_r.chipSel_b) || $fell(pins_r.writeStrobe_b)
    |-> $stable(pins_r.addr))
    else $error("address moved at write start");
  chk_strobe_addr_hold: assert property ($rose(pins_r.writeStrobe_b) && !$past(pins_r.chipSel_b)
    |-> $stable(pins_r.addr) ##1 $stable(pins_r.addr))
    else $error("address not held after strobe rise");
  chk_cs_addr_hold: assert property ($rose(pins_r.chipSel_b) |-> $stable(pins_r.addr))
    else $error("address moved before chip select rise");
  chk_cs_pulse_width: assert property ($rose(pins_r.chipSel_b) |-> csLow_r >= PULSE_A)
    else $error("chip select pulse too short");
  chk_we_before_cs: assert property ($rose(pins_r.chipSel_b) && !pins_r.writeStrobe_b
    |-> $past(weLow_r) >= WE_CYC)
    else $error("strobe low too short before chip select rise");
  chk_addr_before_end: assert property (writeEnd |-> $past(addrAge_r) >= ADDR_END_CYC)
    else $error("address valid too short before write end");
  chk_read_drive_off: assert property (pins_r.outDrive_b)
    else $error("output drive asserted during write traffic");
  chk_retain_deselect: assert property (retainReady |-> pins_r.chipSel_b && $past(pins_r.chipSel_b))
    else $error("retention entered with chip select low");
  chk_cycle_time: assert property ($changed(pins_r.addr) |-> $past(addrAge_r) >= CYCLE_CYC)
    else $error("address changed inside cycle time");
  chk_data_window: assert property ($rose(pins_r.dataOe) |-> $past(!pins_r.writeStrobe_b)
    ##[1:4] !pins_r.dataOe && pins_r.chipSel_b)
    else $error("data driven outside the released window");

  cov_strobe_write: cover property (writeEnd && $rose(pins_r.writeStrobe_b));
  cov_select_write: cover property (writeEnd && $rose(pins_r.chipSel_b));
  cov_retention: cover property ($rose(retainReady) ##[1:20] reqReady);
endmodule // asw_sram_writer

// *** asw_sram_model.sv ***
// behavioural 512k x 8 asynchronous memory on the far side of the write controller
module asw_sram_model (
  input wire logic [18:0] addr,      // address pins
  input wire logic chipSel_b,        // chip select, active low
  input wire logic writeStrobe_b,    // write strobe, active low
  input wire logic outDrive_b,       // output drive, active low
  input wire logic [7:0] dq,         // resolved data wire level
  output logic [7:0] memData,        // value the memory would drive
  output logic memOe                 // high while the memory drives the wire
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:524287];
  //////////////////////////////////////////////////////////////////////////////
  // drives only when selected and reading; turns on late, lets go at once
  assign #(4, 0) memOe = !chipSel_b && writeStrobe_b && !outDrive_b;
  assign memData = mem[addr];
  //////////////////////////////////////////////////////////////////////////////
  // store on the first rising control while the other is still low
  always @(posedge writeStrobe_b) begin
    if (chipSel_b === 1'b0) mem[addr] = dq;
  end
  always @(posedge chipSel_b) begin
    if (writeStrobe_b === 1'b0) mem[addr] = dq;
  end
endmodule // asw_sram_model

// *** tb_async_sram_write_cycle.sv ***
// self-checking bench for the asynchronous memory write controller
module tb_async_sram_write_cycle;
  timeunit 1ns;
  timeprecision 100ps;
  import asw_pkg::*;
  logic clock, rst_b, reqValid, reqReady, writeDone, retainReq, retainReady, memOe;
  asw_req_t req;
  asw_pins_t pins;
  logic [7:0] dq, busSample, memData, dqLast;
  int error_cnt = 0;
  int check_count = 0;
  // control pattern {chipSel_b, writeStrobe_b, dataOe} for cycles 1..5
  logic [2:0] tabS [1:5] = '{3'h6, 3'h0, 3'h1, 3'h3, 3'h6};
  logic [2:0] tabC [1:5] = '{3'h6, 3'h4, 3'h1, 3'h5, 3'h6};
  asw_sram_writer i_asw_sram_writer (.clock(clock), .rst_b(rst_b), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .writeDone(writeDone), .retainReq(retainReq),
    .retainReady(retainReady), .sramPins(pins), .sramDataIn(dq), .busSample(busSample));
  asw_sram_model i_asw_sram_model (.addr(pins.addr), .chipSel_b(pins.chipSel_b),
    .writeStrobe_b(pins.writeStrobe_b), .outDrive_b(pins.outDrive_b), .dq(dq),
    .memData(memData), .memOe(memOe));
  //////////////////////////////////////////////////////////////////////////////
  // wire level: a clash shows unknown, an undriven wire flips so stale data never passes
  assign dq = (pins.dataOe && memOe) ? 8'hxx : pins.dataOe ? pins.dataOut :
    memOe ? memData : ~dqLast;
  always @(posedge clock) begin
    if (pins.dataOe || memOe) dqLast <= dq;
  end
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one write, walked cycle by cycle from the take edge
  task automatic do_write(input logic [18:0] a, input logic [7:0] d, input logic cs);
    logic [2:0] e;
    int n;
    req = '{addr: a, data: d, csCtl: cs};
    reqValid = 1'b1;
    n = 0;
    // let the combinational ready settle before reading it
    #1;
    while (reqReady !== 1'b1 && n < 20) begin
      @(negedge clock);
      #1;
      n++;
    end
    check("reqReady", reqReady, 1'b1);
    for (int c = 1; c <= 6; c++) begin
      @(negedge clock);
      reqValid = 1'b0;
      check("writeDone", writeDone, c == 6);
      if (c < 6) begin
        e = cs ? tabC[c] : tabS[c];
        check("controls", {pins.chipSel_b, pins.writeStrobe_b, pins.dataOe}, e);
        check("outDrive_b", pins.outDrive_b, 1'b1);
        if (c < 5) check("addr", pins.addr, a);
        if (c == 3) check("dq", dq, d);
      end
    end
    check("stored", i_asw_sram_model.mem[a], d);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic write_strobe();
    do_write(19'h12345, 8'ha5, 1'b0);
  endtask
  task automatic write_cs();
    do_write(19'h0abcd, 8'h3c, 1'b1);
  endtask
  // back to back at the address extremes, one select-mode write then two strobe-mode writes
  task automatic back_to_back();
    do_write(19'h7ffff, 8'hff, 1'b1);
    do_write(19'h00000, 8'h00, 1'b0);
    do_write(19'h7ffff, 8'h5a, 1'b0);
    check("kept", i_asw_sram_model.mem[19'h00000], 8'h00);
  endtask
  // park for low supply with a request pending, then recover and write
  task automatic retention();
    req = '{addr: 19'h00777, data: 8'h81, csCtl: 1'b0};
    reqValid = 1'b1;
    retainReq = 1'b1;
    @(negedge clock);
    check("retainReady", retainReady, 1'b1);
    check("chipSel_b", pins.chipSel_b, 1'b1);
    check("refused", reqReady, 1'b0);
    retainReq = 1'b0;
    @(negedge clock);
    check("retainReady off", retainReady, 1'b0);
    check("recover", reqReady, 1'b0);
    @(negedge clock);
    check("idle again", reqReady, 1'b1);
    do_write(19'h00777, 8'h81, 1'b0);
  endtask
  // data pin level reaches busSample two edges later
  task automatic bus_sample();
    logic [7:0] w;
    w = dq;
    @(negedge clock);
    @(negedge clock);
    check("busSample", busSample, w);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    reqValid = 1'b0;
    retainReq = 1'b0;
    req = '0;
    dqLast = 8'h00;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    check("idle pins", {pins.chipSel_b, pins.writeStrobe_b, pins.dataOe}, 3'h6);
    write_strobe();
    write_cs();
    back_to_back();
    retention();
    bus_sample();
    report_and_stop();
  end
  // watchdog at 2000 cycles, well beyond the sixty or so cycles the tests take
  initial begin
    #(40 * 2000);
    error_cnt++;
    report_and_stop();
  end
endmodule // tb_async_sram_write_cycle
